//--- shared/qrs_pkg.sv
// Shared constants for the quad reset supervisor with watchdog
package qrs_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;

  // Delay and timeout figures in microseconds
  localparam int unsigned T_LONG_US = 300000;
  localparam int unsigned T_SHORT_US = 20000;
  localparam int unsigned T_WDOG_US = 610000;
  localparam int unsigned T_PROG_MIN_US = 1400;
  localparam int unsigned T_PROG_MAX_US = 10000000;
  localparam int unsigned T_PULL_US = 10;
  localparam int unsigned T_SETTLE_US = 5;

  // Derived cycle counts (integer times, so exact)
  localparam int unsigned LONG_CYC = T_LONG_US * CLK_MHZ;
  localparam int unsigned SHORT_CYC = T_SHORT_US * CLK_MHZ;
  localparam int unsigned WDOG_CYC = T_WDOG_US * CLK_MHZ;
  localparam int unsigned PROG_MIN_CYC = T_PROG_MIN_US * CLK_MHZ;
  localparam int unsigned PROG_MAX_CYC = T_PROG_MAX_US * CLK_MHZ;
  localparam logic [11:0] PULL_CYC = 12'(T_PULL_US * CLK_MHZ);
  localparam logic [11:0] SETTLE_CYC = 12'(T_SETTLE_US * CLK_MHZ);

  // ----------------------------------------------------------------
  // Widths and indices
  // ----------------------------------------------------------------
  localparam int unsigned NCH = 4;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned SYNC_W = 19;
  localparam int unsigned PRIMARY = 0;
  localparam int unsigned WINDOW_CH = 3;

  // Positions inside the synchronised input vector
  localparam int unsigned POS_RAIL = 0;
  localparam int unsigned POS_HIGH = 4;
  localparam int unsigned POS_MR = 5;
  localparam int unsigned POS_KICK = 6;
  localparam int unsigned POS_PIN = 7;
  localparam int unsigned POS_CAP = 11;
  localparam int unsigned POS_RAMP = 15;

  // Values after reset
  localparam logic [SYNC_W-1:0] SYNC_RST = 19'h00000;

  // ----------------------------------------------------------------
  // State and mode encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DET_PULL = 3'h1,
    DET_SETTLE = 3'h2,
    DET_RUN = 3'h4
  } det_state_t;

  typedef enum logic [2:0] {
    MODE_LONG = 3'h1,
    MODE_SHORT = 3'h2,
    MODE_PROG = 3'h4
  } delay_mode_t;

endpackage

//--- design/quad_reset_supervisor_wdt.sv
// Four-channel reset supervisor with release delays and a latching watchdog
module quad_reset_supervisor_wdt #(
  parameter int unsigned LONG_CYC = qrs_pkg::LONG_CYC,
  parameter int unsigned SHORT_CYC = qrs_pkg::SHORT_CYC,
  parameter int unsigned WDOG_CYC = qrs_pkg::WDOG_CYC,
  parameter int unsigned PROG_MIN_CYC = qrs_pkg::PROG_MIN_CYC,
  parameter int unsigned PROG_MAX_CYC = qrs_pkg::PROG_MAX_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_rail_sense_in,
  input wire logic i_window_high_sense,
  input wire logic i_manual_reset_n,
  input wire logic i_watchdog_kick_in,
  input wire logic [3:0] i_delay_select_pin,
  input wire logic [3:0] i_delay_cap_present,
  input wire logic [3:0] i_ramp_at_end,
  output logic [3:0] o_delay_select_pin,
  output logic [3:0] o_delay_select_pin_oe_n,
  output logic [3:0] o_ramp_charge_en,
  output logic [3:0] o_channel_reset_out_n,
  output logic o_watchdog_fault_out_n
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [qrs_pkg::SYNC_W-1:0] raw;
  logic [qrs_pkg::SYNC_W-1:0] s1_r;
  logic [qrs_pkg::SYNC_W-1:0] s2_r;
  logic [qrs_pkg::SYNC_W-1:0] s3_r;
  logic [qrs_pkg::SYNC_W-1:0] flt_r;
  logic [qrs_pkg::SYNC_W-1:0] flt_nxt;

  assign raw = {i_ramp_at_end, i_delay_cap_present, i_delay_select_pin,
                i_watchdog_kick_in, i_manual_reset_n, i_window_high_sense,
                i_rail_sense_in};

  // A bit only changes once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < qrs_pkg::SYNC_W; g++) begin : g_sync
      always_comb begin
        flt_nxt[g] = flt_r[g];
        if (s2_r[g] == s3_r[g]) begin
          flt_nxt[g] = s3_r[g];
        end
      end
    end
  endgenerate

  // Three-flop chain, first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_r <= qrs_pkg::SYNC_RST;
      s2_r <= qrs_pkg::SYNC_RST;
      s3_r <= qrs_pkg::SYNC_RST;
      flt_r <= qrs_pkg::SYNC_RST;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= flt_nxt;
    end
  end

  // Named views of the filtered inputs
  logic [3:0] rail_ok;
  logic high_over;
  logic mr_n;
  logic kick;
  logic [3:0] pin_hi;
  logic [3:0] cap_seen;
  logic [3:0] ramp_end;
  assign rail_ok = flt_r[qrs_pkg::POS_RAIL +: 4];
  assign high_over = flt_r[qrs_pkg::POS_HIGH];
  assign mr_n = flt_r[qrs_pkg::POS_MR];
  assign kick = flt_r[qrs_pkg::POS_KICK];
  assign pin_hi = flt_r[qrs_pkg::POS_PIN +: 4];
  assign cap_seen = flt_r[qrs_pkg::POS_CAP +: 4];
  assign ramp_end = flt_r[qrs_pkg::POS_RAMP +: 4];

  // ----------------------------------------------------------------
  // Delay pin detection at power-on
  // ----------------------------------------------------------------
  qrs_pkg::det_state_t det_r;
  qrs_pkg::det_state_t det_nxt;
  logic [11:0] dcnt_r;
  logic [11:0] dcnt_nxt;
  qrs_pkg::delay_mode_t mode_r [4];
  qrs_pkg::delay_mode_t mode_nxt [4];
  logic det_done;

  assign det_done = (det_r == qrs_pkg::DET_RUN);

  // Pull pins low, let them settle, then classify once
  always_comb begin
    det_nxt = det_r;
    dcnt_nxt = dcnt_r + 12'h001;
    for (int i = 0; i < 4; i++) begin
      mode_nxt[i] = mode_r[i];
    end
    case (det_r)
      qrs_pkg::DET_PULL: begin
        if (dcnt_r >= qrs_pkg::PULL_CYC - 12'h001) begin
          det_nxt = qrs_pkg::DET_SETTLE;
          dcnt_nxt = 12'h000;
        end
      end
      qrs_pkg::DET_SETTLE: begin
        if (dcnt_r >= qrs_pkg::SETTLE_CYC - 12'h001) begin
          det_nxt = qrs_pkg::DET_RUN;
          // Pull-up wins, else capacitor, else open pin
          for (int i = 0; i < 4; i++) begin
            if (pin_hi[i]) begin
              mode_nxt[i] = qrs_pkg::MODE_LONG;
            end else if (cap_seen[i]) begin
              mode_nxt[i] = qrs_pkg::MODE_PROG;
            end else begin
              mode_nxt[i] = qrs_pkg::MODE_SHORT;
            end
          end
        end
      end
      qrs_pkg::DET_RUN: begin
        dcnt_nxt = dcnt_r;
      end
      default: begin
        det_nxt = qrs_pkg::DET_PULL;
        dcnt_nxt = 12'h000;
      end
    endcase
  end

  // Detection registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      det_r <= qrs_pkg::DET_PULL;
      dcnt_r <= 12'h000;
      for (int i = 0; i < 4; i++) begin
        mode_r[i] <= qrs_pkg::MODE_SHORT;
      end
    end else begin
      det_r <= det_nxt;
      dcnt_r <= dcnt_nxt;
      for (int i = 0; i < 4; i++) begin
        mode_r[i] <= mode_nxt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Release conditions per channel
  // ----------------------------------------------------------------
  logic [3:0] cond_ok;
  // Primary needs manual reset high and rail good
  assign cond_ok[0] = rail_ok[0] & mr_n;
  // Plain under-threshold channels
  assign cond_ok[2:1] = rail_ok[2:1];
  // Window: low side above and high side below together
  assign cond_ok[3] = rail_ok[3] & ~high_over;

  // ----------------------------------------------------------------
  // Channel delay counters and reset outputs
  // ----------------------------------------------------------------
  logic [3:0] rst_r;
  logic [3:0] rst_nxt;
  logic [3:0] oe_n_r;
  logic [3:0] oe_n_nxt;
  logic [3:0] chg_r;
  logic [3:0] chg_nxt;
  logic [qrs_pkg::CNT_W-1:0] cnt_r [4];
  logic [qrs_pkg::CNT_W-1:0] cnt_nxt [4];

  generate
    for (g = 0; g < qrs_pkg::NCH; g++) begin : g_ch
      logic done;
      // End of delay per detected mode
      always_comb begin
        case (mode_r[g])
          qrs_pkg::MODE_LONG: done = (cnt_r[g] >= LONG_CYC);
          qrs_pkg::MODE_PROG: done = (cnt_r[g] >= PROG_MIN_CYC && ramp_end[g]) ||
                                     (cnt_r[g] >= PROG_MAX_CYC);
          default: done = (cnt_r[g] >= SHORT_CYC);
        endcase
      end

      // Assert at once, release only when the delay ends
      always_comb begin
        rst_nxt[g] = rst_r[g];
        cnt_nxt[g] = cnt_r[g];
        if (!det_done || !cond_ok[g]) begin
          rst_nxt[g] = 1'b1;
          cnt_nxt[g] = '0;
        end else if (rst_r[g]) begin
          if (done) begin
            rst_nxt[g] = 1'b0;
          end else begin
            cnt_nxt[g] = cnt_r[g] + 32'h00000001;
          end
        end
        // Pin is pulled low in the pull phase of detection and to discharge the capacitor
        oe_n_nxt[g] = !((det_r == qrs_pkg::DET_PULL) ||
                        (det_done && mode_r[g] == qrs_pkg::MODE_PROG && !cond_ok[g]));
        chg_nxt[g] = det_done && mode_r[g] == qrs_pkg::MODE_PROG && cond_ok[g] &&
                     rst_r[g];
      end

      // Channel registers
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          rst_r[g] <= 1'b1;
          cnt_r[g] <= '0;
          oe_n_r[g] <= 1'b1;
          chg_r[g] <= 1'b0;
        end else begin
          rst_r[g] <= rst_nxt[g];
          cnt_r[g] <= cnt_nxt[g];
          oe_n_r[g] <= oe_n_nxt[g];
          chg_r[g] <= chg_nxt[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  logic kick_d_r;
  logic kick_d_nxt;
  logic fault_r;
  logic fault_nxt;
  logic [qrs_pkg::CNT_W-1:0] wcnt_r;
  logic [qrs_pkg::CNT_W-1:0] wcnt_nxt;
  logic kick_edge;

  // Either edge counts; found on the filtered copy
  assign kick_edge = kick ^ kick_d_r;

  // Count while primary released; latch fault until primary reasserts
  always_comb begin
    kick_d_nxt = kick;
    fault_nxt = fault_r;
    wcnt_nxt = wcnt_r;
    if (rst_r[qrs_pkg::PRIMARY]) begin
      fault_nxt = 1'b0;
      wcnt_nxt = '0;
    end else if (!fault_r) begin
      if (kick_edge) begin
        wcnt_nxt = '0;
      end else if (wcnt_r >= WDOG_CYC - 32'h00000001) begin
        fault_nxt = 1'b1;
      end else begin
        wcnt_nxt = wcnt_r + 32'h00000001;
      end
    end
  end

  // Watchdog registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      kick_d_r <= 1'b0;
      fault_r <= 1'b0;
      wcnt_r <= '0;
    end else begin
      kick_d_r <= kick_d_nxt;
      fault_r <= fault_nxt;
      wcnt_r <= wcnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops except the constant pin drive
  // ----------------------------------------------------------------
  assign o_channel_reset_out_n = ~rst_r;
  assign o_watchdog_fault_out_n = ~fault_r;
  assign o_delay_select_pin = 4'h0; // Only ever pulls low
  assign o_delay_select_pin_oe_n = oe_n_r;
  assign o_ramp_charge_en = chg_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_fault_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !rst_r[0] && !fault_r && !kick_edge && wcnt_r == WDOG_CYC - 1 |=> fault_r)
    else $error("watchdog did not time out at terminal count");
  a_wdog_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rst_r[0] |=> wcnt_r == '0 && !fault_r)
    else $error("watchdog ran while primary asserted");
  a_kick_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !rst_r[0] && !fault_r && kick_edge |=> wcnt_r == '0)
    else $error("kick edge did not clear watchdog count");
  a_fault_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fault_r && !rst_r[0] |=> fault_r)
    else $error("fault cleared without primary reset");
  a_rel_delay: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(rst_r[1]) && mode_r[1] == qrs_pkg::MODE_LONG |-> $past(cnt_r[1]) >= LONG_CYC)
    else $error("channel released before its delay");
  a_assert_fast: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    det_done && !cond_ok[2] |=> rst_r[2] && cnt_r[2] == '0)
    else $error("channel not asserted at once");
  a_mr_primary: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !mr_n ##1 !mr_n |-> rst_r[0])
    else $error("manual reset did not hold primary");
  a_window_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    high_over |=> o_channel_reset_out_n[3] == 1'b0)
    else $error("window channel released while over threshold");
  a_detect_pull: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rst_n && det_r == qrs_pkg::DET_PULL ##1 det_r == qrs_pkg::DET_PULL |-> oe_n_r == 4'h0)
    else $error("delay pins not pulled during detection");
  a_prog_ramp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(rst_r[2]) && mode_r[2] == qrs_pkg::MODE_PROG |->
      $past(ramp_end[2]) || $past(cnt_r[2]) >= PROG_MAX_CYC)
    else $error("programmable release without ramp end");

endmodule

//--- tb/proc_reset_model.sv
// Far-side processor model: held by the primary reset, kicks the watchdog
module proc_reset_model #(
  parameter int unsigned KICK_CYC = 200
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_kick_en,
  output logic o_kick
);
  timeunit 1ns;
  timeprecision 1ps;

  // Start values by declaration, so each variable has one driving process
  int unsigned cnt_r = 0;
  logic kick_r = 1'b0;

  assign o_kick = kick_r;

  // Software loop runs only out of reset; kicks stop when the bench wants a hang
  always @(posedge i_clk) begin
    if (!i_reset_n || !i_kick_en) begin
      cnt_r <= 0;
    end else if (cnt_r == KICK_CYC - 1) begin
      cnt_r <= 0;
      kick_r <= ~kick_r;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule

//--- tb/quad_reset_supervisor_wdt_tb.sv
// Self-checking bench for the quad reset supervisor with watchdog
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module quad_reset_supervisor_wdt_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Shortened counts and bench state
  // ----------------------------------------------------------------
  localparam int LONG = 300;
  localparam int SHORT = 100;
  localparam int WDOG = 500;
  localparam int PMIN = 50;
  localparam int DET = int'(qrs_pkg::PULL_CYC) + int'(qrs_pkg::SETTLE_CYC);
  typedef struct {int bitn; logic val; int lo; int hi;} note_t;
  note_t notes[$];
  note_t nt;
  int cyc = 0, last_kick = 0, mismatches = 0, total_checks = 0, s;
  logic started, kick_en;
  logic [31:0] lfsr_r;
  logic [4:0] outs, prev;
  logic i_clk, i_rst_n, i_window_high_sense, i_manual_reset_n, i_watchdog_kick_in;
  logic [3:0] i_rail_sense_in, i_delay_select_pin, i_delay_cap_present, i_ramp_at_end;
  logic [3:0] o_delay_select_pin, o_delay_select_pin_oe_n, o_ramp_charge_en;
  logic [3:0] o_channel_reset_out_n;
  logic o_watchdog_fault_out_n;

  // Pin level: pulled low when enabled, else only channel 1 has a pull-up
  assign i_delay_select_pin = (~o_delay_select_pin_oe_n & o_delay_select_pin)
                              | (o_delay_select_pin_oe_n & 4'h2);

  quad_reset_supervisor_wdt #(.LONG_CYC(LONG), .SHORT_CYC(SHORT), .WDOG_CYC(WDOG),
    .PROG_MIN_CYC(PMIN), .PROG_MAX_CYC(2000)) dut (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_rail_sense_in(i_rail_sense_in),
    .i_window_high_sense(i_window_high_sense),
    .i_manual_reset_n(i_manual_reset_n),
    .i_watchdog_kick_in(i_watchdog_kick_in),
    .i_delay_select_pin(i_delay_select_pin),
    .i_delay_cap_present(i_delay_cap_present),
    .i_ramp_at_end(i_ramp_at_end),
    .o_delay_select_pin(o_delay_select_pin),
    .o_delay_select_pin_oe_n(o_delay_select_pin_oe_n),
    .o_ramp_charge_en(o_ramp_charge_en),
    .o_channel_reset_out_n(o_channel_reset_out_n),
    .o_watchdog_fault_out_n(o_watchdog_fault_out_n));

  proc_reset_model #(.KICK_CYC(200)) partner (.i_clk(i_clk),
    .i_reset_n(o_channel_reset_out_n[0]), .i_kick_en(kick_en), .o_kick(i_watchdog_kick_in));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) cyc <= cyc + 1;
  always @(i_watchdog_kick_in) last_kick = cyc;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Next state of the stimulus shift register
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic expect_edge(input int b, input logic v, input int lo, input int hi);
    notes.push_back('{b, v, lo, hi});
  endtask

  // Bounded wait for all noted output changes to show up
  task automatic wait_drain(input int n);
    for (int i = 0; i < n && notes.size() != 0; i++) @(posedge i_clk);
    `CHK(notes.size(), 0)
    repeat (20) @(posedge i_clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Drop a rail for a random time, glitch it again mid-delay, then release
  task automatic drop_chan(input int ch, input int d);
    int hold;
    lfsr_r = lfsr_step(lfsr_r);
    hold = 20 + int'(lfsr_r[5:0]);
    @(posedge i_clk);
    i_rail_sense_in[ch] <= 1'b0;
    expect_edge(ch, 1'b0, cyc + 1, cyc + 8);
    repeat (hold) @(posedge i_clk);
    if (ch == 2) begin
      @(negedge i_clk);
      `CHK(o_ramp_charge_en[2], 1'b0)
      @(posedge i_clk);
    end
    i_rail_sense_in[ch] <= 1'b1;
    repeat (d / 2 + 5) @(posedge i_clk);
    i_rail_sense_in[ch] <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_rail_sense_in[ch] <= 1'b1;
    if (ch == 2) begin
      repeat (60) @(negedge i_clk);
      `CHK(o_ramp_charge_en[2], 1'b1)
      repeat (60) @(posedge i_clk);
      i_ramp_at_end[2] <= 1'b1; // Cap sized for the wanted delay
    end
    expect_edge(ch, 1'b1, cyc + d, cyc + d + 14);
    wait_drain(d + 60);
    i_ramp_at_end[2] <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Watcher: every output change consumes the oldest note
  // ----------------------------------------------------------------
  always @(negedge i_clk) begin
    outs = {o_watchdog_fault_out_n, o_channel_reset_out_n};
    for (int b = 0; b < 5; b++) begin
      if (started && outs[b] !== prev[b]) begin
        if (notes.size() == 0) begin
          `CHK(outs[b], prev[b])
        end else begin
          nt = notes.pop_front();
          `CHK(b, nt.bitn)
          `CHK(outs[b], nt.val)
          `CHK(cyc >= nt.lo && cyc <= nt.hi, 1'b1)
        end
      end
    end
    prev = outs;
  end

  // Hang guard, sized well above the full sequence length
  initial begin
    repeat (40000) @(posedge i_clk);
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    lfsr_r = 32'h2791d3cc;
    started = 1'b0;
    kick_en = 1'b1;
    i_rst_n = 1'b0;
    i_rail_sense_in = 4'hf;
    i_window_high_sense = 1'b0;
    i_manual_reset_n = 1'b1;
    i_delay_cap_present = 4'h4;
    i_ramp_at_end = 4'h4; // Ramp already at end: startup release at the minimum
    lfsr_r = lfsr_step(lfsr_r);
    @(posedge i_clk);
    i_delay_cap_present[1] <= lfsr_r[0]; // Pull-up must win over a cap flag
    repeat (4) @(negedge i_clk);
    `CHK(o_channel_reset_out_n, 4'h0)
    `CHK(o_watchdog_fault_out_n, 1'b1)
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    started = 1'b1;
    s = cyc + DET;
    expect_edge(2, 1'b1, s + PMIN, s + PMIN + 25);
    expect_edge(0, 1'b1, s + SHORT, s + SHORT + 25);
    expect_edge(3, 1'b1, s + SHORT, s + SHORT + 25);
    expect_edge(1, 1'b1, s + LONG, s + LONG + 25);
    repeat (10) @(negedge i_clk);
    `CHK(o_delay_select_pin_oe_n, 4'h0)
    `CHK(o_delay_select_pin, 4'h0)
    repeat (2500) @(negedge i_clk);
    `CHK(o_delay_select_pin_oe_n, 4'hf)
    wait_drain(DET + LONG);
    i_ramp_at_end <= 4'h0;
    drop_chan(0, SHORT);
    drop_chan(1, LONG);
    drop_chan(2, 0);
    drop_chan(3, SHORT);
    // Window: high side trips, then low side holds it until both are good
    i_window_high_sense <= 1'b1;
    expect_edge(3, 1'b0, cyc + 1, cyc + 8);
    repeat (20) @(posedge i_clk);
    i_rail_sense_in[3] <= 1'b0;
    repeat (20) @(posedge i_clk);
    i_window_high_sense <= 1'b0;
    repeat (SHORT + 30) @(posedge i_clk);
    i_rail_sense_in[3] <= 1'b1;
    expect_edge(3, 1'b1, cyc + SHORT, cyc + SHORT + 14);
    wait_drain(SHORT + 40);
    // Manual reset overrides a good rail; release needs both good
    i_manual_reset_n <= 1'b0;
    expect_edge(0, 1'b0, cyc + 1, cyc + 8);
    repeat (20) @(posedge i_clk);
    i_rail_sense_in[0] <= 1'b0;
    repeat (20) @(posedge i_clk);
    i_rail_sense_in[0] <= 1'b1;
    repeat (SHORT + 30) @(posedge i_clk);
    i_manual_reset_n <= 1'b1;
    expect_edge(0, 1'b1, cyc + SHORT, cyc + SHORT + 14);
    wait_drain(SHORT + 40);
    // Regular kicks keep the fault away; a hang trips and latches it
    repeat (WDOG + 100) @(posedge i_clk);
    kick_en <= 1'b0;
    repeat (2) @(posedge i_clk);
    expect_edge(4, 1'b0, last_kick + WDOG, last_kick + WDOG + 14);
    wait_drain(WDOG + 40);
    kick_en <= 1'b1;
    repeat (WDOG + 100) @(posedge i_clk);
    i_manual_reset_n <= 1'b0;
    kick_en <= 1'b0;
    expect_edge(0, 1'b0, cyc + 1, cyc + 8);
    expect_edge(4, 1'b1, cyc + 1, cyc + 10);
    repeat (WDOG + 100) @(posedge i_clk);
    i_manual_reset_n <= 1'b1;
    expect_edge(0, 1'b1, cyc + SHORT, cyc + SHORT + 14);
    expect_edge(4, 1'b0, cyc + SHORT + WDOG, cyc + SHORT + WDOG + 30);
    wait_drain(SHORT + WDOG + 60);
    give_verdict();
  end
endmodule
